// ---- rtl/cis_consts.svh ----
// register map, field positions and reset values of the interrupt selector
`ifndef CIS_CONSTS_SVH
`define CIS_CONSTS_SVH
`define CIS_ADDR_SEL_UPPER 32'h019c0000
`define CIS_ADDR_SEL_LOWER 32'h019c0004
`define CIS_ADDR_STATUS 32'h019c0008
`define CIS_ADDR_CLEAR 32'h019c000c
`define CIS_ADDR_ENABLE 32'h019c0010
`define CIS_RST_SEL_UPPER 32'h08202d43
`define CIS_RST_SEL_LOWER 32'h250718a4
`define CIS_SEL_WMASK 32'h7fff7fff
`define CIS_FLD_W 5
`define CIS_FLD0_LSB 0
`define CIS_FLD1_LSB 5
`define CIS_FLD2_LSB 10
`define CIS_FLD3_LSB 16
`define CIS_FLD4_LSB 21
`define CIS_FLD5_LSB 26
`define CIS_CODE_CELL_BUS 5'h17
`define CIS_CODE_VITERBI 5'h1e
`define CIS_CODE_TURBO 5'h1f
`define CIS_N_LINES 16
`define CIS_N_FIXED 4
`define CIS_RESP_OKAY 2'h0
`define CIS_RESP_SLVERR 2'h2
`endif

// ---- rtl/cis_pkg.sv ----
// types shared by the interrupt selector
package cis_pkg;
    // selector register layout, six 5-bit fields with two zero gaps
    typedef struct packed {
        logic gap31;
        logic [4:0] fld5;
        logic [4:0] fld4;
        logic [4:0] fld3;
        logic gap15;
        logic [4:0] fld2;
        logic [4:0] fld1;
        logic [4:0] fld0;
    } cis_sel_s;
    // peripheral event lines, all synchronous to aclk
    typedef struct packed {
        logic host_irq;
        logic timer_zero_irq;
        logic timer_one_irq;
        logic wide_sdram_refresh_irq;
        logic [3:0] gpio_or_pin_event;
        logic dma_channel_combined_irq;
        logic emulation_transfer_event;
        logic emulation_exchange_rx;
        logic emulation_exchange_tx;
        logic serial0_tx_irq;
        logic serial0_rx_irq;
        logic serial1_tx_irq;
        logic serial1_rx_irq;
        logic gpio_event_zero;
        logic serial2_tx_irq;
        logic serial2_rx_irq;
        logic timer_two_irq;
        logic narrow_sdram_refresh_irq;
        logic cell_bus_irq;
        logic viterbi_coproc_irq;
        logic turbo_coproc_irq;
    } cis_evt_s;
    typedef logic [4:0] cis_code_t;
endpackage : cis_pkg

// ---- rtl/cis_top.sv ----
// interrupt selector: event routing onto sixteen cpu lines, axi4-lite regs
`timescale 1ns/1ps
`include "cis_consts.svh"
// Functional notes
// - sixteen cpu interrupt lines, fixed priorities
// - line 0 reset, highest; 15 lowest
// - lines 0..3 fixed, selectors never touch
// - lines 4..15 follow own 5-bit field
// - upper register lines 10..15, lower 4..9
// - lower fields lines 4..7, gpio defaults
// - line 8 dma, line 9 emulation defaults
// - lines 10..12 sdram, exchange rx/tx defaults
// - lines 13..15 host, timer 0, timer 1
// - serial, gpio0, timer2, narrow sdram codes
// - codes 11110/11111 coprocessors when present
// - cell bus code 10111 when present
module cis_top #(
    parameter bit HAS_COPROC = 1'b1,
    parameter bit HAS_CELL_BUS = 1'b1
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // event sources
    input wire logic reset_evt,
    input wire logic nmi_evt,
    input wire cis_pkg::cis_evt_s periph_evt,
    // cpu side
    output logic [15:0] cpu_int,
    output logic irq
);
    import cis_pkg::*;

    // ************************************************************
    // event source table indexed by selector code
    // ************************************************************
    logic [31:0] src_w;
    assign src_w[0] = periph_evt.host_irq;
    assign src_w[1] = periph_evt.timer_zero_irq;
    assign src_w[2] = periph_evt.timer_one_irq;
    assign src_w[3] = periph_evt.wide_sdram_refresh_irq;
    assign src_w[7:4] = periph_evt.gpio_or_pin_event;
    assign src_w[8] = periph_evt.dma_channel_combined_irq;
    assign src_w[9] = periph_evt.emulation_transfer_event;
    assign src_w[10] = periph_evt.emulation_exchange_rx;
    assign src_w[11] = periph_evt.emulation_exchange_tx;
    // serial ports 0 and 1
    assign src_w[12] = periph_evt.serial0_tx_irq;
    assign src_w[13] = periph_evt.serial0_rx_irq;
    assign src_w[14] = periph_evt.serial1_tx_irq;
    assign src_w[15] = periph_evt.serial1_rx_irq;
    assign src_w[16] = periph_evt.gpio_event_zero;
    assign src_w[17] = periph_evt.serial2_tx_irq;
    assign src_w[18] = periph_evt.serial2_rx_irq;
    assign src_w[19] = periph_evt.timer_two_irq;
    assign src_w[20] = periph_evt.narrow_sdram_refresh_irq;
    // reserved codes select a quiet line
    assign src_w[22:21] = 2'h0;
    assign src_w[23] = HAS_CELL_BUS & periph_evt.cell_bus_irq;
    assign src_w[29:24] = 6'h00;
    assign src_w[30] = HAS_COPROC & periph_evt.viterbi_coproc_irq;
    assign src_w[31] = HAS_COPROC & periph_evt.turbo_coproc_irq;

    // ************************************************************
    // selector registers and per-line routing
    // ************************************************************
    cis_sel_s sel_up_q, sel_lo_q;
    cis_sel_s sel_up_d, sel_lo_d;
    logic [59:0] codes_w;
    logic [11:0] route_w;

    // lower fields feed lines 4..9, upper fields lines 10..15
    assign codes_w = {sel_up_q.fld5, sel_up_q.fld4, sel_up_q.fld3,
                      sel_up_q.fld2, sel_up_q.fld1, sel_up_q.fld0,
                      sel_lo_q.fld5, sel_lo_q.fld4, sel_lo_q.fld3,
                      sel_lo_q.fld2, sel_lo_q.fld1, sel_lo_q.fld0};

    // one multiplexer per maskable line
    genvar gi;
    generate
        for (gi = 0; gi < 12; gi++) begin : g_line
            wire cis_code_t code_w = codes_w[gi*5 +: 5];
            assign route_w[gi] = src_w[code_w];
        end
    endgenerate

    // ************************************************************
    // axi4-lite write channel
    // ************************************************************
    logic aw_have_q, w_have_q;
    logic [31:0] aw_addr_q, w_data_q;
    logic [3:0] w_strb_q;
    logic awready_q, wready_q, bvalid_q;
    logic [1:0] bresp_q;
    logic aw_fire_w, w_fire_w, wr_go_w;
    logic [31:0] wr_addr_w, wr_data_w;
    logic [3:0] wr_strb_w;
    logic [31:0] wr_mask_w;
    logic wr_up_w, wr_lo_w, wr_clr_w, wr_en_w, wr_hit_w;

    assign aw_fire_w = awvalid & awready_q;
    assign w_fire_w = wvalid & wready_q;
    // write happens once both halves are present
    assign wr_go_w = (aw_have_q | aw_fire_w) & (w_have_q | w_fire_w)
                     & ~bvalid_q;
    assign wr_addr_w = aw_have_q ? aw_addr_q : awaddr;
    assign wr_data_w = w_have_q ? w_data_q : wdata;
    assign wr_strb_w = w_have_q ? w_strb_q : wstrb;
    assign wr_mask_w = {{8{wr_strb_w[3]}}, {8{wr_strb_w[2]}},
                        {8{wr_strb_w[1]}}, {8{wr_strb_w[0]}}};
    // address decode
    assign wr_up_w = wr_go_w & (wr_addr_w == `CIS_ADDR_SEL_UPPER);
    assign wr_lo_w = wr_go_w & (wr_addr_w == `CIS_ADDR_SEL_LOWER);
    assign wr_clr_w = wr_go_w & (wr_addr_w == `CIS_ADDR_CLEAR);
    assign wr_en_w = wr_go_w & (wr_addr_w == `CIS_ADDR_ENABLE);
    assign wr_hit_w = wr_up_w | wr_lo_w | wr_clr_w | wr_en_w
                      | (wr_addr_w == `CIS_ADDR_STATUS);

    // byte-merged selector values, gap bits forced to zero
    assign sel_up_d = wr_up_w
        ? ((sel_up_q & ~wr_mask_w) | (wr_data_w & wr_mask_w))
          & `CIS_SEL_WMASK
        : sel_up_q;
    assign sel_lo_d = wr_lo_w
        ? ((sel_lo_q & ~wr_mask_w) | (wr_data_w & wr_mask_w))
          & `CIS_SEL_WMASK
        : sel_lo_q;

    // address and data holding
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
        end else begin
            aw_have_q <= (aw_have_q | aw_fire_w) & ~wr_go_w;
            w_have_q <= (w_have_q | w_fire_w) & ~wr_go_w;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr_q <= 32'h00000000;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
        end else begin
            if (aw_fire_w) aw_addr_q <= awaddr;
            if (w_fire_w) w_data_q <= wdata;
            if (w_fire_w) w_strb_q <= wstrb;
        end
    end

    // ready and response flags
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= `CIS_RESP_OKAY;
        end else begin
            awready_q <= ~(aw_have_q | aw_fire_w) | wr_go_w;
            wready_q <= ~(w_have_q | w_fire_w) | wr_go_w;
            bvalid_q <= wr_go_w | (bvalid_q & ~bready);
            if (wr_go_w)
                bresp_q <= wr_hit_w ? `CIS_RESP_OKAY : `CIS_RESP_SLVERR;
        end
    end

    // selector registers, defaults after reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_up_q <= `CIS_RST_SEL_UPPER;
            sel_lo_q <= `CIS_RST_SEL_LOWER;
        end else begin
            sel_up_q <= sel_up_d;
            sel_lo_q <= sel_lo_d;
        end
    end

    // ************************************************************
    // cpu lines, event status and interrupt
    // ************************************************************
    logic [15:0] cpu_int_q;
    logic [15:0] cpu_int_d;
    logic [11:0] status_q;
    logic [11:0] status_d;
    logic [11:0] enable_q;
    logic irq_q;

    // fixed lines 0..3, selected lines 4..15
    assign cpu_int_d = {route_w, 2'h0, nmi_evt, reset_evt};
    // set wins over a clear in the same cycle
    assign status_d = (status_q & ~(wr_clr_w ? wr_data_w[11:0] : 12'h000))
                      | (cpu_int_d[15:4] & ~cpu_int_q[15:4]);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_int_q <= 16'h0000;
            status_q <= 12'h000;
            enable_q <= 12'h000;
            irq_q <= 1'b0;
        end else begin
            cpu_int_q <= cpu_int_d;
            status_q <= status_d;
            if (wr_en_w) enable_q <= wr_data_w[11:0];
            irq_q <= |(status_d & (wr_en_w ? wr_data_w[11:0] : enable_q));
        end
    end

    // ************************************************************
    // axi4-lite read channel
    // ************************************************************
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic ar_fire_w;
    logic rd_hit_w;
    logic [31:0] rd_data_w;

    assign ar_fire_w = arvalid & arready_q;
    // read data select, clear register reads as zero
    assign rd_data_w =
        (araddr == `CIS_ADDR_SEL_UPPER) ? sel_up_q :
        (araddr == `CIS_ADDR_SEL_LOWER) ? sel_lo_q :
        (araddr == `CIS_ADDR_STATUS) ? {20'h00000, status_q} :
        (araddr == `CIS_ADDR_ENABLE) ? {20'h00000, enable_q} :
        32'h00000000;
    assign rd_hit_w = (araddr == `CIS_ADDR_SEL_UPPER)
                    | (araddr == `CIS_ADDR_SEL_LOWER)
                    | (araddr == `CIS_ADDR_STATUS)
                    | (araddr == `CIS_ADDR_CLEAR)
                    | (araddr == `CIS_ADDR_ENABLE);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= `CIS_RESP_OKAY;
        end else begin
            arready_q <= ~ar_fire_w & ~(rvalid_q & ~rready);
            rvalid_q <= ar_fire_w | (rvalid_q & ~rready);
            if (ar_fire_w) rdata_q <= rd_data_w;
            if (ar_fire_w)
                rresp_q <= rd_hit_w ? `CIS_RESP_OKAY : `CIS_RESP_SLVERR;
        end
    end

    // outputs straight from flops
    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign cpu_int = cpu_int_q;
    assign irq = irq_q;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_wr_full(logic [31:0] a);
        wr_go_w && wr_addr_w == a && wr_strb_w == 4'hf;
    endsequence

    property p_route;
        aresetn && $past(aresetn) |-> cpu_int_q[15:4] == $past(route_w);
    endproperty
    a_route: assert property (p_route)
        else $error("maskable line not from its selected source");

    property p_fixed;
        aresetn && $past(aresetn) |->
            cpu_int_q[3:2] == 2'h0 && cpu_int_q[1] == $past(nmi_evt)
            && cpu_int_q[0] == $past(reset_evt);
    endproperty
    a_fixed: assert property (p_fixed)
        else $error("fixed line does not follow its source");

    property p_defaults;
        aresetn && !$past(aresetn) |->
            sel_up_q == `CIS_RST_SEL_UPPER && sel_lo_q == `CIS_RST_SEL_LOWER;
    endproperty
    a_defaults: assert property (p_defaults)
        else $error("selector default wrong after reset");

    property p_gaps;
        sel_up_q.gap15 == 1'b0 && sel_up_q.gap31 == 1'b0
        && sel_lo_q.gap15 == 1'b0 && sel_lo_q.gap31 == 1'b0;
    endproperty
    a_gaps: assert property (p_gaps)
        else $error("selector gap bit set");

    property p_wr_upper;
        logic [31:0] v;
        (s_wr_full(`CIS_ADDR_SEL_UPPER), v = wr_data_w) |=>
            sel_up_q == (v & `CIS_SEL_WMASK)
            ##1 cpu_int_q[15:10] == $past(route_w[11:6]);
    endproperty
    a_wr_upper: assert property (p_wr_upper)
        else $error("upper selector write not applied");

    property p_wr_lower;
        logic [31:0] v;
        (s_wr_full(`CIS_ADDR_SEL_LOWER), v = wr_data_w) |=>
            sel_lo_q == (v & `CIS_SEL_WMASK);
    endproperty
    a_wr_lower: assert property (p_wr_lower)
        else $error("lower selector write not applied");

    property p_line13;
        sel_up_q.fld3 == 5'h01 |-> ##1 cpu_int_q[13] == $past(src_w[1]);
    endproperty
    a_line13: assert property (p_line13)
        else $error("line 13 not following timer code");

    property p_absent;
        src_w[29:24] == 6'h00 && src_w[22:21] == 2'h0
        && (HAS_COPROC || src_w[31:30] == 2'h0);
    endproperty
    a_absent: assert property (p_absent)
        else $error("absent or reserved source is active");

    property p_cell;
        HAS_CELL_BUS |-> src_w[23] == periph_evt.cell_bus_irq;
    endproperty
    a_cell: assert property (p_cell)
        else $error("cell bus code not routed");

    // response raised after a write and held until the master takes it
    property p_bresp;
        wr_go_w || (bvalid_q && !bready) |=> bvalid_q;
    endproperty
    a_bresp: assert property (p_bresp)
        else $error("write response dropped before taken");

    property p_irq;
        (status_q & enable_q) != 12'h000 && !wr_clr_w && !wr_en_w
            |=> irq_q;
    endproperty
    a_irq: assert property (p_irq)
        else $error("enabled status without interrupt");
endmodule : cis_top

// ---- sim/cis_evt_model.sv ----
// event source model for the peripherals around the interrupt selector
`timescale 1ns/1ps
module cis_evt_model (
    // clock
    input wire logic aclk,
    // requested levels, bit n is the source of selector code n
    input wire logic [31:0] src_req,
    input wire logic reset_req,
    input wire logic nmi_req,
    // event lines towards the selector
    output logic reset_evt,
    output logic nmi_evt,
    output cis_pkg::cis_evt_s periph_evt
);
    import cis_pkg::*;
    logic [31:0] src_q;
    // sources move just after an edge, like on-chip logic
    always_ff @(posedge aclk) begin
        src_q <= src_req;
        reset_evt <= reset_req;
        nmi_evt <= nmi_req;
    end
    // code number to event line, in struct order
    assign periph_evt = cis_evt_s'({src_q[0], src_q[1], src_q[2], src_q[3],
        src_q[7:4], src_q[8], src_q[9], src_q[10], src_q[11], src_q[12],
        src_q[13], src_q[14], src_q[15], src_q[16], src_q[17], src_q[18],
        src_q[19], src_q[20], src_q[23], src_q[30], src_q[31]});
endmodule : cis_evt_model

// ---- sim/cis_top_tb.sv ----
// self-checking bench of the interrupt selector
`timescale 1ns/1ps
`include "cis_consts.svh"
module cis_top_tb;
    import cis_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic reset_evt, nmi_evt, reset_req, nmi_req;
    logic [31:0] awaddr, wdata, araddr, rdata, src_req;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [15:0] cpu_int;
    cis_evt_s periph_evt;
    int num_errors = 0;
    int checks_done = 0;
    logic [31:0] sh [2];
    int lsb [6] = '{0, 5, 10, 16, 21, 26};
    logic [4:0] dflt [12] = '{5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09,
        5'h03, 5'h0a, 5'h0b, 5'h00, 5'h01, 5'h02};
    logic [31:0] radr [2] = '{`CIS_ADDR_SEL_LOWER, `CIS_ADDR_SEL_UPPER};

    cis_top u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .reset_evt(reset_evt), .nmi_evt(nmi_evt),
        .periph_evt(periph_evt), .cpu_int(cpu_int), .irq(irq));
    cis_evt_model u_src (.aclk(aclk), .src_req(src_req),
        .reset_req(reset_req), .nmi_req(nmi_req), .reset_evt(reset_evt),
        .nmi_evt(nmi_evt), .periph_evt(periph_evt));

    // ****************************************
    // clock, watchdog and verdict
    // ****************************************
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    initial begin
        #60000;
        num_errors++;
        summarize();
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize

    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input logic [31:0] got, exp, input string m);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s got %h exp %h", $time, m, got,
                exp);
        end
    endtask : chk
    // three edges: request, model output, cpu line register
    task automatic settle();
        repeat (3) @(posedge aclk);
        #1;
    endtask : settle
    // one axi4-lite write, each channel released when taken
    task automatic axw(input logic [31:0] a, d, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready));
        r = bresp;
        bready <= 1'b0;
    endtask : axw
    task automatic axr(input logic [31:0] a, output logic [31:0] d,
        output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready));
        r = rresp;
        d = rdata;
        rready <= 1'b0;
    endtask : axr
    task automatic wr(input logic [31:0] a, d);
        logic [1:0] r;
        axw(a, d, r);
        chk(r, `CIS_RESP_OKAY, "write response");
    endtask : wr
    task automatic rd_chk(input logic [31:0] a, exp, input string m);
        logic [1:0] r;
        logic [31:0] d;
        axr(a, d, r);
        chk(r, `CIS_RESP_OKAY, "read response");
        chk(d, exp, m);
    endtask : rd_chk
    // shadow words built from the default code of each line
    task automatic load_defaults();
        sh[0] = 32'h0;
        sh[1] = 32'h0;
        for (int n = 0; n < 12; n++) sh[n / 6][lsb[n % 6] +: 5] = dflt[n];
    endtask : load_defaults
    task automatic set_field(input int line, input logic [4:0] c);
        int ri;
        ri = (line >= 10) ? 1 : 0;
        sh[ri][lsb[(line - 4) % 6] +: 5] = c;
        wr(radr[ri], sh[ri]);
    endtask : set_field

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        load_defaults();
        chk(cpu_int, 16'h0, "lines after reset");
        rd_chk(radr[0], sh[0], "lower reset");
        rd_chk(radr[1], sh[1], "upper reset");
        rd_chk(`CIS_ADDR_STATUS, 32'h0, "status reset");
        rd_chk(`CIS_ADDR_ENABLE, 32'h0, "enable reset");
        $display("test reset done");
    endtask : t_reset
    task automatic t_fixed();
        src_req <= 32'hffffffff;
        settle();
        chk(cpu_int, 16'hfff0, "all sources, fixed lines quiet");
        reset_req <= 1'b1;
        settle();
        chk(cpu_int, 16'hfff1, "line 0 follows reset");
        reset_req <= 1'b0;
        nmi_req <= 1'b1;
        settle();
        chk(cpu_int, 16'hfff2, "line 1 follows nmi");
        nmi_req <= 1'b0;
        src_req <= 32'h0;
        settle();
        chk(cpu_int, 16'h0, "all sources low");
        $display("test fixed lines done");
    endtask : t_fixed
    task automatic t_defaults();
        for (int n = 0; n < 12; n++) begin
            src_req <= 32'h1 << dflt[n];
            settle();
            chk(cpu_int, 32'h10 << n, "default source");
        end
        src_req <= 32'h0;
        $display("test default routing done");
    endtask : t_defaults
    task automatic t_codes();
        int n;
        n = 0;
        for (int c = 0; c < 32; c++) begin
            // reserved codes are never programmed
            if ((c > 20 && c < 23) || (c > 23 && c < 30)) continue;
            @(posedge aclk);
            src_req <= 32'h1 << c;
            settle();
            set_field(4 + n % 12, c[4:0]);
            #1;
            chk(cpu_int[4 + n % 12], 1'b1, "new code next clock");
            @(posedge aclk);
            src_req <= 32'h0;
            settle();
            chk(cpu_int, 16'h0, "line drops with source");
            n++;
        end
        set_field(13, 5'h01);
        @(posedge aclk);
        src_req <= 32'h2;
        settle();
        chk(cpu_int[13], 1'b1, "line 13 on timer 0 code");
        @(posedge aclk);
        src_req <= 32'h0;
        load_defaults();
        wr(radr[0], sh[0]);
        wr(radr[1], sh[1]);
        $display("test code table done");
    endtask : t_codes
    task automatic t_regs();
        logic [1:0] r;
        logic [31:0] d;
        wr(radr[0], 32'hffffffff);
        rd_chk(radr[0], ~32'h80008000, "lower gap bits");
        wr(radr[1], 32'hffffffff);
        rd_chk(radr[1], ~32'h80008000, "upper gap bits");
        wr(radr[0], sh[0]);
        wr(radr[1], sh[1]);
        rd_chk(radr[1], sh[1], "upper rewritten");
        rd_chk(`CIS_ADDR_CLEAR, 32'h0, "clear reads zero");
        axw(32'h019c0014, 32'h1, r);
        chk(r, `CIS_RESP_SLVERR, "unmapped write");
        axr(32'h019c0014, d, r);
        chk(r, `CIS_RESP_SLVERR, "unmapped read");
        chk(d, 32'h0, "unmapped data");
        $display("test registers done");
    endtask : t_regs
    task automatic t_irq();
        // earlier tests left status bits set
        wr(`CIS_ADDR_CLEAR, 32'hfff);
        rd_chk(`CIS_ADDR_STATUS, 32'h0, "status cleared first");
        wr(`CIS_ADDR_ENABLE, 32'h1);
        @(posedge aclk);
        src_req <= 32'h1 << dflt[0];
        settle();
        chk(irq, 1'b1, "irq raised");
        rd_chk(`CIS_ADDR_STATUS, 32'h1, "status set");
        wr(`CIS_ADDR_ENABLE, 32'h0);
        settle();
        chk(irq, 1'b0, "irq masked");
        wr(`CIS_ADDR_ENABLE, 32'h1);
        @(posedge aclk);
        src_req <= 32'h0;
        settle();
        chk(irq, 1'b1, "status sticky");
        wr(`CIS_ADDR_CLEAR, 32'h1);
        settle();
        chk(irq, 1'b0, "irq cleared");
        rd_chk(`CIS_ADDR_STATUS, 32'h0, "status cleared");
        $display("test interrupt done");
    endtask : t_irq

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        aresetn = 1'b0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        awaddr = 32'h0;
        wdata = 32'h0;
        araddr = 32'h0;
        wstrb = 4'hf;
        src_req = 32'h0;
        reset_req = 1'b0;
        nmi_req = 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        #1;
        t_reset();
        t_fixed();
        t_defaults();
        t_codes();
        t_regs();
        t_irq();
        summarize();
    end
endmodule : cis_top_tb
